/* File: common/pot_wiper_cfg.svh */
`ifndef POT_WIPER_CFG_SVH
`define POT_WIPER_CFG_SVH

// slave address, upper seven bits, that selects the potentiometers
`define DEV_ADDR 7'h57
// instruction byte fields
`define INSTR_TYPE_BIT 7
`define POT_SEL_RESERVED 2'h3
// highest tap code per pot
`define POT0_MAX 8'h3f
`define POT1_MAX 8'h63
`define POT2_MAX 8'hff
// valid read-back bits per pot
`define POT0_READ_MASK 8'h3f
`define POT1_READ_MASK 8'h7f
`define POT2_READ_MASK 8'hff
// wiper register contents before the power-up recall
`define POT0_INIT 8'h3f
`define POT1_INIT 8'h00
`define POT2_INIT 8'hff
// stored wiper value as shipped
`define STORED_RESET 8'h00
// bit counter positions
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
// store cycle
`define STORE_TIME_MS 5
`define CLOCK_MHZ 200
`define STORE_CYCLES (`STORE_TIME_MS * `CLOCK_MHZ * 1000)

`endif

/* File: common/pot_wiper_pkg.sv */
package pot_wiper_pkg;

  typedef logic [2:0][7:0] wiper_bank_t;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_INSTR,
    PH_DATA,
    PH_READ
  } link_phase_t;

  typedef struct packed {
    logic [1:0] pot;
    logic nv;
    logic [7:0] value;
  } write_req_t;

  typedef struct packed {
    logic seen;
    link_phase_t ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ack;
    logic rw;
    logic [1:0] pot;
    logic nv;
    logic [7:0] tx;
    logic drv_low;
    logic wr_tog;
    write_req_t req;
    logic [1:0] wel_s;
    logic [1:0] lock_s;
    logic [1:0] busy_s;
    wiper_bank_t wip_s1;
    wiper_bank_t wip_s2;
  } link_state_t;

  typedef struct packed {
    logic [2:0] wr_s;
    logic [2:0] stop_s;
    wiper_bank_t wiper;
    wiper_bank_t stored;
    logic recall;
    logic pend;
    logic busy;
    logic [19:0] timer;
  } sys_state_t;

endpackage : pot_wiper_pkg

/* File: src/pot_wiper_serial_access.sv */
`include "pot_wiper_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pot_wiper_serial_access #(
  parameter int STORE_CYCLES = `STORE_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic write_enable_latch,
  input wire logic pot_write_lock,
  output pot_wiper_pkg::wiper_bank_t wiper_position_reg,
  output pot_wiper_pkg::wiper_bank_t stored_wiper_value,
  output logic store_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // stand-in for the supplied 100-tap table: codes past the top saturate
  function automatic logic [7:0] clamp_tap(input logic [1:0] pot,
                                           input logic [7:0] d);
    logic [7:0] mx;
    case (pot)
      2'h0: mx = `POT0_MAX;
      2'h1: mx = `POT1_MAX;
      default: mx = `POT2_MAX;
    endcase
    clamp_tap = (d > mx) ? mx : d;
  endfunction : clamp_tap

  function automatic logic [7:0] read_mask(input logic [1:0] pot);
    case (pot)
      2'h0: read_mask = `POT0_READ_MASK;
      2'h1: read_mask = `POT1_READ_MASK;
      default: read_mask = `POT2_READ_MASK;
    endcase
  endfunction : read_mask

  ////////////////////////////////////////////////////////////////////////////
  // start and stop detection on the data line edges

  logic start_tog_q;
  logic stop_tog_q;

  always_ff @(negedge sda_i or posedge sys_rst) begin
    if (sys_rst) begin
      start_tog_q <= 1'b0;
    end else if (scl_i) begin
      start_tog_q <= ~start_tog_q;
    end
  end

  always_ff @(posedge sda_i or posedge sys_rst) begin
    if (sys_rst) begin
      stop_tog_q <= 1'b0;
    end else if (scl_i) begin
      stop_tog_q <= ~stop_tog_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side, clocked by the serial clock

  pot_wiper_pkg::link_state_t l_q;
  pot_wiper_pkg::link_state_t l_d;
  pot_wiper_pkg::sys_state_t s_q;
  pot_wiper_pkg::sys_state_t s_d;
  logic [7:0] byte_in;
  logic out_low_q;

  always_comb begin
    byte_in = {l_q.sh[6:0], sda_i};
    l_d = l_q;
    l_d.wel_s = {l_q.wel_s[0], write_enable_latch};
    l_d.lock_s = {l_q.lock_s[0], pot_write_lock};
    l_d.busy_s = {l_q.busy_s[0], s_q.busy};
    // wiper bank only changes after a write or the recall after reset, long before it is read back
    l_d.wip_s1 = s_q.wiper;
    l_d.wip_s2 = l_q.wip_s1;
    l_d.drv_low = 1'b0;
    if (start_tog_q != l_q.seen) begin
      // first rising edge of a frame carries address bit 7
      l_d.seen = start_tog_q;
      l_d.ph = pot_wiper_pkg::PH_ADDR;
      l_d.cnt = 4'h1;
      l_d.sh = byte_in;
    end else begin
      case (l_q.ph)
        pot_wiper_pkg::PH_ADDR,
        pot_wiper_pkg::PH_INSTR,
        pot_wiper_pkg::PH_DATA: begin
          if (l_q.cnt < `BIT_LAST) begin
            l_d.sh = byte_in;
            l_d.cnt = l_q.cnt + 4'h1;
          end else if (l_q.cnt == `BIT_LAST) begin
            l_d.sh = byte_in;
            l_d.cnt = `BIT_ACK;
            case (l_q.ph)
              pot_wiper_pkg::PH_ADDR: begin
                // busy store cycle answers polling with no acknowledge
                l_d.ack = (byte_in[7:1] == `DEV_ADDR)
                          && !l_q.busy_s[1];
                l_d.rw = byte_in[0];
              end
              pot_wiper_pkg::PH_INSTR: begin
                l_d.ack = (byte_in[1:0] != `POT_SEL_RESERVED);
                l_d.pot = byte_in[1:0];
                l_d.nv = byte_in[`INSTR_TYPE_BIT];
              end
              default: begin
                l_d.ack = l_q.wel_s[1] && !l_q.lock_s[1];
                if (l_d.ack) begin
                  l_d.req.pot = l_q.pot;
                  l_d.req.nv = l_q.nv;
                  l_d.req.value = clamp_tap(l_q.pot, byte_in);
                  l_d.wr_tog = ~l_q.wr_tog;
                end
              end
            endcase
            l_d.drv_low = l_d.ack;
          end else begin
            l_d.cnt = 4'h0;
            if (!l_q.ack) begin
              l_d.ph = pot_wiper_pkg::PH_IDLE;
            end else begin
              case (l_q.ph)
                pot_wiper_pkg::PH_ADDR: begin
                  if (l_q.rw) begin
                    l_d.ph = pot_wiper_pkg::PH_READ;
                    l_d.tx = l_q.wip_s2[l_q.pot]
                             & read_mask(l_q.pot);
                    l_d.drv_low = ~l_d.tx[7];
                  end else begin
                    l_d.ph = pot_wiper_pkg::PH_INSTR;
                  end
                end
                pot_wiper_pkg::PH_INSTR: l_d.ph = pot_wiper_pkg::PH_DATA;
                // one data byte per write; later bytes go unanswered
                default: l_d.ph = pot_wiper_pkg::PH_IDLE;
              endcase
            end
          end
        end
        pot_wiper_pkg::PH_READ: begin
          if (l_q.cnt < `BIT_LAST) begin
            l_d.cnt = l_q.cnt + 4'h1;
            l_d.tx = {l_q.tx[6:0], 1'b0};
            l_d.drv_low = ~l_d.tx[7];
          end else if (l_q.cnt == `BIT_LAST) begin
            l_d.cnt = `BIT_ACK;
          end else begin
            l_d.cnt = 4'h0;
            l_d.ph = pot_wiper_pkg::PH_IDLE;
          end
        end
        default: l_d.ph = pot_wiper_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge scl_i or posedge sys_rst) begin
    if (sys_rst) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // the line changes only while the clock is low
  always_ff @(negedge scl_i or posedge sys_rst) begin
    if (sys_rst) begin
      out_low_q <= 1'b0;
    end else begin
      out_low_q <= l_q.drv_low;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = ~out_low_q;

  ////////////////////////////////////////////////////////////////////////////
  // system side: wiper bank, stored values, store cycle

  always_comb begin
    s_d = s_q;
    s_d.wr_s = {s_q.wr_s[1:0], l_q.wr_tog};
    s_d.stop_s = {s_q.stop_s[1:0], stop_tog_q};
    if (s_q.recall) begin
      s_d.wiper = s_q.stored;
      s_d.recall = 1'b0;
    end else if (s_q.wr_s[2] != s_q.wr_s[1]) begin
      // request word was registered on the same serial clock edge as its toggle and holds while the toggle crosses
      s_d.wiper[l_q.req.pot] = l_q.req.value;
      if (l_q.req.nv) begin
        s_d.stored[l_q.req.pot] = l_q.req.value;
        s_d.pend = 1'b1;
      end
    end
    if (s_q.busy) begin
      if (s_q.timer == 20'h00000) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.timer = s_q.timer - 20'h00001;
      end
    end else if (s_q.pend && (s_q.stop_s[2] != s_q.stop_s[1])) begin
      s_d.pend = 1'b0;
      s_d.busy = 1'b1;
      s_d.timer = 20'(STORE_CYCLES - 1);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_q.wr_s <= 3'h0;
      s_q.stop_s <= 3'h0;
      s_q.wiper <= {`POT2_INIT, `POT1_INIT, `POT0_INIT};
      s_q.stored <= {3{`STORED_RESET}};
      s_q.recall <= 1'b1;
      s_q.pend <= 1'b0;
      s_q.busy <= 1'b0;
      s_q.timer <= 20'h00000;
    end else begin
      s_q <= s_d;
    end
  end

  assign wiper_position_reg = s_q.wiper;
  assign stored_wiper_value = s_q.stored;
  assign store_busy = s_q.busy;

endmodule : pot_wiper_serial_access

`default_nettype wire

/* File: bench/pot_wiper_props.sv */
`include "pot_wiper_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pot_wiper_props #(parameter int STORE_CYCLES = 50) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic write_enable_latch,
  input wire logic pot_write_lock,
  input wire pot_wiper_pkg::wiper_bank_t wiper_position_reg,
  input wire pot_wiper_pkg::wiper_bank_t stored_wiper_value,
  input wire logic store_busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  int busy_n;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) busy_n <= 0;
    else busy_n <= store_busy ? busy_n + 1 : 0;
  end
  a_stored_top: assert property (stored_wiper_value[0] <= `POT0_MAX &&
    stored_wiper_value[1] <= `POT1_MAX) else $error("stored above top tap");
  for (genvar k = 0; k < 3; k++) begin : g_pot
    a_nv_pair: assert property (!$stable(stored_wiper_value[k]) |->
      wiper_position_reg[k] == stored_wiper_value[k])
      else $error("stored value differs from wiper");
  end
  a_store_len: assert property ($fell(store_busy) |->
    busy_n inside {[STORE_CYCLES-1:STORE_CYCLES+1]})
    else $error("store cycle length wrong");
  a_top_tap: assert property (wiper_position_reg[0] <= `POT0_MAX &&
    wiper_position_reg[1] <= `POT1_MAX) else $error("wiper above top tap");
  // the recall after reset is the only legal change without the latch
  a_write_gate: assert property (!$stable(wiper_position_reg) &&
    !$past(sys_rst) && !$past(sys_rst, 2) |->
    write_enable_latch && !pot_write_lock) else $error("write not gated");
  a_reset_recall: assert property ($fell(sys_rst) |=>
    wiper_position_reg == stored_wiper_value) else $error("no recall");
  a_busy_no_ack: assert property (store_busy |-> sda_oe_n)
    else $error("acknowledge while storing");
  a_store_follows: assert property (!$stable(stored_wiper_value) |->
    ##[1:200] store_busy) else $error("no store cycle");
endmodule : pot_wiper_props
bind pot_wiper_serial_access pot_wiper_props #(.STORE_CYCLES(STORE_CYCLES))
  pot_wiper_props_inst (.clock(clock), .sys_rst(sys_rst), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .write_enable_latch(write_enable_latch),
  .pot_write_lock(pot_write_lock), .wiper_position_reg(wiper_position_reg),
  .stored_wiper_value(stored_wiper_value), .store_busy(store_busy));
`default_nettype wire

/* File: bench/serial_master.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_master (
  output logic scl,
  output logic sda_pull,
  input wire logic sda,
  output logic rx_stb,
  output logic [7:0] rx_val
);
  // quarter of the 32 ns serial clock; scl rests high between frames
  localparam realtime Q = 8.0;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rx_stb = 1'b0;
    rx_val = 8'h00;
  end
  task automatic start();
    sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : start
  task automatic xfer(input logic [7:0] b, input logic rd);
    logic [7:0] v;
    logic a;
    for (int i = 7; i >= 0; i--) begin
      sda_pull = !rd && !b[i];
      #Q scl = 1'b1;
      #Q v[i] = sda;
      #Q scl = 1'b0;
      #Q;
    end
    sda_pull = 1'b0; // a read byte is always answered by no acknowledge
    #Q scl = 1'b1;
    #Q a = sda;
    #Q scl = 1'b0;
    #Q;
    rx_val = rd ? v : {7'h00, a};
    rx_stb = 1'b1;
    #1 rx_stb = 1'b0;
  endtask : xfer
  task automatic stop();
    sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #Q;
  endtask : stop
endmodule : serial_master
`default_nettype wire

/* File: bench/pot_wiper_serial_access_tb.sv */
`include "pot_wiper_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pot_wiper_serial_access_tb;
  localparam int STORE = 400;
  logic clock, sys_rst, write_enable_latch, pot_write_lock, sda_o, sda_oe_n;
  logic store_busy, scl, sda_pull, rx_stb;
  logic [7:0] rx_val;
  pot_wiper_pkg::wiper_bank_t wiper_position_reg, stored_wiper_value;
  pot_wiper_pkg::wiper_bank_t exp_w, exp_s;
  wire logic sda = !(sda_pull || (!sda_oe_n && !sda_o));
  logic [23:0] expq[$];
  int miscompares = 0;
  int comparisons = 0;
  pot_wiper_serial_access #(.STORE_CYCLES(STORE)) pot_wiper_serial_access_inst (
    .clock(clock), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .write_enable_latch(write_enable_latch),
    .pot_write_lock(pot_write_lock), .wiper_position_reg(wiper_position_reg),
    .stored_wiper_value(stored_wiper_value), .store_busy(store_busy));
  serial_master serial_master_inst (.scl(scl), .sda_pull(sda_pull), .sda(sda),
    .rx_stb(rx_stb), .rx_val(rx_val));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic note(input logic [23:0] v);
    expq.push_back(v);
  endtask : note
  always @(posedge rx_stb) begin
    check("serial", 24'(rx_val), expq.size() > 0 ? expq.pop_front() : 'x);
  end
  task automatic wr(input logic [7:0] a, ins, d, input logic [2:0] e);
    for (int i = 2; i >= 0; i--) note(24'(e[i]));
    serial_master_inst.start();
    serial_master_inst.xfer(a, 1'b0);
    serial_master_inst.xfer(ins, 1'b0);
    serial_master_inst.xfer(d, 1'b0);
    serial_master_inst.stop();
    repeat (20) @(negedge clock);
  endtask : wr
  task automatic rd(input logic [1:0] p, input logic [7:0] e);
    repeat (3) note(24'h000000);
    note(24'(e));
    serial_master_inst.start();
    serial_master_inst.xfer(8'hae, 1'b0);
    serial_master_inst.xfer({1'($urandom), 5'h00, p}, 1'b0);
    serial_master_inst.start();
    serial_master_inst.xfer(8'haf, 1'b0);
    serial_master_inst.xfer(8'hff, 1'b1);
    serial_master_inst.stop();
  endtask : rd
  task automatic poll(input logic e);
    note(24'(e));
    serial_master_inst.start();
    serial_master_inst.xfer(8'hae, 1'b0);
    serial_master_inst.stop();
  endtask : poll
  task automatic settle();
    for (int i = 0; i < 2 * STORE && store_busy !== 1'b0; i++) @(negedge clock);
  endtask : settle
  function automatic logic [7:0] sat(input int p, input logic [7:0] d);
    logic [7:0] m;
    m = p == 0 ? `POT0_MAX : p == 1 ? `POT1_MAX : `POT2_MAX;
    return d > m ? m : d;
  endfunction : sat
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    int r;
    logic nv;
    logic [7:0] d;
    sys_rst = 1'b1;
    write_enable_latch = 1'b0;
    pot_write_lock = 1'b0;
    exp_w = '0;
    exp_s = '0;
    r = $urandom(84);
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    repeat (40) @(negedge clock);
    check("recall", wiper_position_reg, 24'h000000);
    write_enable_latch = 1'b1;
    for (int k = 0; k < 6; k++) begin
      nv = 1'($urandom);
      d = (k == 3 || k == 4) ? 8'hc8 : 8'($urandom);
      wr(8'hae, {nv, 5'h00, 2'(k % 3)}, d, 3'b000);
      exp_w[k % 3] = sat(k % 3, d);
      if (nv) exp_s[k % 3] = exp_w[k % 3];
      settle();
      check("wiper", wiper_position_reg, exp_w);
      check("stored", stored_wiper_value, exp_s);
      rd(2'(k % 3), exp_w[k % 3]);
    end
    $display("test 1 done");
    wr(8'hae, 8'h82, 8'h11, 3'b000);
    exp_w[2] = 8'h11;
    exp_s[2] = 8'h11;
    poll(1'b1);
    settle();
    poll(1'b0);
    $display("test 2 done");
    wr(8'hae, 8'h03, 8'h05, 3'b011);
    wr(8'ha4, 8'h00, 8'h05, 3'b111);
    write_enable_latch = 1'b0;
    wr(8'hae, 8'h80, 8'h22, 3'b001);
    write_enable_latch = 1'b1;
    pot_write_lock = 1'b1;
    wr(8'hae, 8'h80, 8'h22, 3'b001);
    pot_write_lock = 1'b0;
    check("wiper", wiper_position_reg, exp_w);
    check("stored", stored_wiper_value, exp_s);
    $display("test 3 done");
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    check("recall", wiper_position_reg, 24'h000000);
    check("stored", stored_wiper_value, 24'h000000);
    $display("test 4 done");
    report_and_stop();
  end
endmodule : pot_wiper_serial_access_tb
`default_nettype wire
